// >>> hdl/rltc_defs.svh
// register offsets, field positions, reset values and timing constants
`ifndef RLTC_DEFS_SVH
`define RLTC_DEFS_SVH

`define RLTC_OFS_CTRL 6'h00
`define RLTC_OFS_RETRY 6'h04
`define RLTC_OFS_STATUS 6'h08
`define RLTC_OFS_PIPE_EN 6'h0C
`define RLTC_OFS_P0_LO 6'h10
`define RLTC_OFS_P0_HI 6'h14
`define RLTC_OFS_P1_LO 6'h18
`define RLTC_OFS_P1_HI 6'h1C
`define RLTC_OFS_LSB25 6'h20

`define RLTC_CTRL_EN 0
`define RLTC_CTRL_ROLE_RX 1
`define RLTC_CTRL_AUTO_RETX 2
`define RLTC_CTRL_AUTO_ACK 3
`define RLTC_CTRL_CRC_EN 4
`define RLTC_CTRL_CRC_TWO 5
`define RLTC_CTRL_ENH 6

`define RLTC_ST_DONE 0
`define RLTC_ST_RXREADY 1
`define RLTC_ST_LIMIT 2

`define RLTC_RST_CTRL 7'h5C
`define RLTC_RST_RETRY 8'h03
`define RLTC_RST_PIPE_EN 6'h03
`define RLTC_RST_P0 40'hE7D3F03577
`define RLTC_RST_P1 40'hC2C2C2C2C2
`define RLTC_RST_LSB25 32'hC6C5C4C3

`define RLTC_CLK_NS 10
`define RLTC_STEP_NS 250000
`define RLTC_ACK_WAIT_NS 250000

`endif

// >>> hdl/rltc_pkg.sv
// types shared by the link transaction controller
package rltc_pkg;
	// gray codes along the transmit path and along the receive path
	typedef enum logic [2:0] {
		RLTC_SBY1 = 3'h0,
		RLTC_TX = 3'h1,
		RLTC_ACK_WAIT = 3'h3,
		RLTC_SBY2 = 3'h2,
		RLTC_RX = 3'h6,
		RLTC_RX_CAPT = 3'h7,
		RLTC_ACK_TX = 3'h5
	} rltc_state_e;

	typedef enum logic [1:0] {
		RLTC_MODE_SBY1 = 2'h0,
		RLTC_MODE_SBY2 = 2'h1,
		RLTC_MODE_TX = 2'h2,
		RLTC_MODE_RX = 2'h3
	} rltc_mode_e;
endpackage

// >>> hdl/rltc_ctrl.sv
// link-layer transaction controller with axi4-lite register slave
// Contract
// - enabled with queued packet: transmit it
// - auto retransmit, ack wanted: await acknowledgement
// - empty ack: raise only done flag
// - payload ack: done and ready, standby-I
// - ack timeout: standby-I until delay elapses
// - below limit after delay: resend same packet
// - limit reached: limit flag, standby-I
// - enabled, queue empty: idle standby-II
// - receiver role enabled: search continuously
// - auto ack: classify new or repeat
// - new packet: write fifo, ready flag
// - delivered ack payload: done flag next packet
// - ack wanted: send ack with payload
// - repeat: drop, still acknowledge
// - six pipes matched, one captures
// - other pipes wait for complete packet
// - shared settings; crc forced when enhanced
// - per-pipe enables; pipes 0,1 after reset
// - pipe 0 full; 1-5 share upper
// - ack destination is arrival pipe address
// - retry delay in 250us steps
// - ack wait ends: no match, or received
// - repeat: same identifier and same crc
// - retry count clears on new transaction
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`include "rltc_defs.svh"
module rltc_ctrl
	import rltc_pkg::*;
#(
	parameter int unsigned STEP_CYC = `RLTC_STEP_NS / `RLTC_CLK_NS,
	parameter int unsigned ACK_WAIT_CYC = `RLTC_ACK_WAIT_NS / `RLTC_CLK_NS
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// axi4-lite slave
	input wire logic [5:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [5:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// transmit queue status and transmitter
	input wire logic txq_nonempty,
	input wire logic txq_skip_ack,
	output logic txq_pop,
	output logic tx_start,
	output logic tx_resend,
	output logic tx_ack_payload,
	output logic [39:0] tx_dest_addr,
	input wire logic tx_end,
	// receiver
	input wire logic [39:0] rx_addr,
	input wire logic rx_addr_valid,
	input wire logic rx_done,
	input wire logic rx_crc_ok,
	input wire logic [1:0] rx_pid,
	input wire logic [15:0] rx_crc,
	input wire logic rx_no_ack,
	input wire logic rx_has_payload,
	output logic rxq_write,
	output logic [2:0] rx_pipe,
	// shared radio settings
	output logic [1:0] radio_mode,
	output logic crc_on,
	output logic crc_two
);
	localparam logic [31:0] STEP = 32'(STEP_CYC);
	localparam logic [31:0] ACK_WAIT = 32'(ACK_WAIT_CYC);

	// byte-lane merge for the 32-bit registers: low words of pipes 0 and 1, and lsb25
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	rltc_state_e state, next_state;
	logic [6:0] ctrl;
	logic [7:0] retry;
	logic [5:0] pipe_en;
	logic [39:0] p0, p1;
	logic [31:0] lsb25;
	logic f_done, f_rxr, f_lim;
	logic [3:0] retry_count;
	logic retry_pend, ackpay_pend, cap_ok, seen;
	logic [31:0] ack_tmr, dly_tmr;
	logic [1:0] last_pid;
	logic [15:0] last_crc;
	logic aw_h, w_h;
	logic [5:0] aw_a;
	logic [31:0] w_d;
	logic [3:0] w_s;

	// control fields
	wire en = ctrl[`RLTC_CTRL_EN];
	wire role_rx = ctrl[`RLTC_CTRL_ROLE_RX];
	wire auto_retx = ctrl[`RLTC_CTRL_AUTO_RETX];
	wire auto_ack = ctrl[`RLTC_CTRL_AUTO_ACK];
	wire [3:0] limit = retry[3:0];
	wire [3:0] delay = retry[7:4];

	// pipe addresses: pipes 2-5 reuse the upper bytes of pipe 1
	wire [39:0] paddr [6];
	assign paddr[0] = p0;
	assign paddr[1] = p1;
	genvar g;
	for (g = 2; g < 6; g++) begin : g_pipe
		assign paddr[g] = {p1[39:8], lsb25[8*(g-2) +: 8]};
	end
	wire [5:0] hit;
	for (g = 0; g < 6; g++) begin : g_hit
		assign hit[g] = pipe_en[g] && rx_addr == paddr[g];
	end
	// lowest pipe wins if software broke uniqueness
	wire [2:0] hit_idx = hit[0] ? 3'h0 : hit[1] ? 3'h1 : hit[2] ? 3'h2 :
		hit[3] ? 3'h3 : hit[4] ? 3'h4 : 3'h5;

	// event decode for both roles
	// the queue level lags a pop by one cycle, so a pop blocks a new start
	wire go_new = state == RLTC_SBY1 && en && !role_rx && !retry_pend &&
		txq_nonempty && !txq_pop;
	wire go_retry = state == RLTC_SBY1 && en && !role_rx && retry_pend &&
		dly_tmr == 32'h0;
	wire tx_fin = state == RLTC_TX && tx_end;
	wire need_ack = auto_retx && !txq_skip_ack;
	wire ack_ok = state == RLTC_ACK_WAIT && rx_done && cap_ok && rx_crc_ok;
	wire ack_lost = state == RLTC_ACK_WAIT && ((rx_done && cap_ok &&
		!rx_crc_ok) || (!cap_ok && ack_tmr == 32'h0));
	wire at_limit = retry_count >= limit;
	wire rx_good = state == RLTC_RX_CAPT && rx_done && rx_crc_ok;
	wire dup_pkt = rx_good && auto_ack && seen && rx_pid == last_pid &&
		rx_crc == last_crc;
	wire new_pkt = rx_good && !dup_pkt;
	wire send_ack = rx_good && auto_ack && !rx_no_ack;

	// write channel decode
	wire wr_go = aw_h && w_h && !s_axi_bvalid;
	wire wr_ok = aw_a <= `RLTC_OFS_LSB25 && aw_a[1:0] == 2'h0;
	wire wr_st = wr_go && aw_a == `RLTC_OFS_STATUS;
	wire [31:0] st_clr = wr_st ? (w_d & {28'h0, w_s[0], w_s[0], w_s[0],
		w_s[0]}) : 32'h0;

	// flag set terms
	wire set_done = (tx_fin && !need_ack) || ack_ok ||
		(new_pkt && ackpay_pend);
	wire set_rxr = (ack_ok && rx_has_payload) || new_pkt;
	wire set_lim = ack_lost && at_limit;

	assign s_axi_awready = !aw_h;
	assign s_axi_wready = !w_h;
	assign s_axi_arready = !s_axi_rvalid;
	assign crc_on = ctrl[`RLTC_CTRL_CRC_EN] | ctrl[`RLTC_CTRL_ENH];
	assign crc_two = ctrl[`RLTC_CTRL_CRC_TWO];

	// next state of the transaction sequencer
	always_comb begin
		next_state = state;
		case (state)
			RLTC_SBY1: begin
				if (en && role_rx) begin
					next_state = RLTC_RX;
				end else if (go_new || (go_retry && !at_limit)) begin
					next_state = RLTC_TX;
				end else if (en && !role_rx && !retry_pend) begin
					next_state = RLTC_SBY2;
				end
			end
			RLTC_SBY2: begin
				if (!en || role_rx || txq_nonempty) begin
					next_state = RLTC_SBY1;
				end
			end
			RLTC_TX: begin
				if (tx_end) begin
					next_state = need_ack ? RLTC_ACK_WAIT : RLTC_SBY1;
				end
			end
			RLTC_ACK_WAIT: begin
				if (ack_ok || ack_lost) begin
					next_state = RLTC_SBY1;
				end
			end
			RLTC_RX: begin
				if (!en || !role_rx) begin
					next_state = RLTC_SBY1;
				end else if (rx_addr_valid && hit != 6'h0) begin
					next_state = RLTC_RX_CAPT;
				end
			end
			RLTC_RX_CAPT: begin
				if (rx_done) begin
					next_state = send_ack ? RLTC_ACK_TX : RLTC_RX;
				end
			end
			RLTC_ACK_TX: begin
				if (tx_end) begin
					next_state = RLTC_RX;
				end
			end
			default: next_state = RLTC_SBY1;
		endcase
	end

	// sequencer registers and pulses
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= RLTC_SBY1;
			tx_start <= 1'b0;
			tx_resend <= 1'b0;
			tx_ack_payload <= 1'b0;
			txq_pop <= 1'b0;
			rxq_write <= 1'b0;
		end else begin
			state <= next_state;
			tx_start <= (next_state == RLTC_TX && state == RLTC_SBY1) ||
				(next_state == RLTC_ACK_TX && state == RLTC_RX_CAPT);
			tx_resend <= go_retry && !at_limit;
			tx_ack_payload <= send_ack ? txq_nonempty : tx_ack_payload;
			txq_pop <= (tx_fin && !need_ack) || ack_ok ||
				(state == RLTC_ACK_TX && tx_end && tx_ack_payload);
			rxq_write <= new_pkt;
		end
	end

	// retry bookkeeping and timers
	always_ff @(posedge clk) begin
		if (srst) begin
			retry_count <= 4'h0;
			retry_pend <= 1'b0;
			ack_tmr <= 32'h0;
			dly_tmr <= 32'h0;
		end else begin
			if (go_new) begin
				retry_count <= 4'h0;
			end else if (go_retry && !at_limit) begin
				retry_count <= retry_count + 4'h1;
			end
			if (ack_lost) begin
				retry_pend <= !at_limit;
			end else if (go_retry || ack_ok) begin
				retry_pend <= 1'b0;
			end
			// both timers start at the end of the sent packet
			if (tx_fin) begin
				ack_tmr <= ACK_WAIT;
				dly_tmr <= 32'({28'h0, delay} + 32'h1) * STEP;
			end else begin
				if (ack_tmr != 32'h0) begin
					ack_tmr <= ack_tmr - 32'h1;
				end
				if (dly_tmr != 32'h0) begin
					dly_tmr <= dly_tmr - 32'h1;
				end
			end
		end
	end

	// capture lock, duplicate history and acknowledgement address
	always_ff @(posedge clk) begin
		if (srst) begin
			cap_ok <= 1'b0;
			rx_pipe <= 3'h0;
			seen <= 1'b0;
			last_pid <= 2'h0;
			last_crc <= 16'h0;
			ackpay_pend <= 1'b0;
			tx_dest_addr <= 40'h0;
		end else begin
			// the lock holds off other pipes until the packet ends
			if (state == RLTC_RX && rx_addr_valid && hit != 6'h0) begin
				rx_pipe <= hit_idx;
			end
			if (state != RLTC_ACK_WAIT || rx_done) begin
				cap_ok <= 1'b0;
			end else if (rx_addr_valid && hit[0]) begin
				cap_ok <= 1'b1;
			end
			if (rx_good) begin
				seen <= 1'b1;
				last_pid <= rx_pid;
				last_crc <= rx_crc;
			end
			if (new_pkt) begin
				ackpay_pend <= 1'b0;
			end
			if (send_ack) begin
				ackpay_pend <= txq_nonempty;
				tx_dest_addr <= paddr[rx_pipe];
			end else if (go_new || go_retry) begin
				tx_dest_addr <= p0;
			end
		end
	end

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (srst) begin
			f_done <= 1'b0;
			f_rxr <= 1'b0;
			f_lim <= 1'b0;
		end else begin
			f_done <= (f_done & ~st_clr[`RLTC_ST_DONE]) | set_done;
			f_rxr <= (f_rxr & ~st_clr[`RLTC_ST_RXREADY]) | set_rxr;
			f_lim <= (f_lim & ~st_clr[`RLTC_ST_LIMIT]) | set_lim;
		end
	end

	// radio mode from the sequencer state
	always_ff @(posedge clk) begin
		if (srst) begin
			radio_mode <= RLTC_MODE_SBY1;
		end else begin
			case (next_state)
				RLTC_SBY2: radio_mode <= RLTC_MODE_SBY2;
				RLTC_TX, RLTC_ACK_TX: radio_mode <= RLTC_MODE_TX;
				RLTC_ACK_WAIT, RLTC_RX, RLTC_RX_CAPT: radio_mode <= RLTC_MODE_RX;
				default: radio_mode <= RLTC_MODE_SBY1;
			endcase
		end
	end

	// axi write: address and data taken in either order
	always_ff @(posedge clk) begin
		if (srst) begin
			aw_h <= 1'b0;
			w_h <= 1'b0;
			aw_a <= 6'h0;
			w_d <= 32'h0;
			w_s <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_h) begin
				aw_h <= 1'b1;
				aw_a <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_h <= 1'b0;
			end
			if (s_axi_wvalid && !w_h) begin
				w_h <= 1'b1;
				w_d <= s_axi_wdata;
				w_s <= s_axi_wstrb;
			end else if (wr_go) begin
				w_h <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// register file writes
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl <= `RLTC_RST_CTRL;
			retry <= `RLTC_RST_RETRY;
			pipe_en <= `RLTC_RST_PIPE_EN;
			p0 <= `RLTC_RST_P0;
			p1 <= `RLTC_RST_P1;
			lsb25 <= `RLTC_RST_LSB25;
		end else if (wr_go) begin
			// narrow registers sit in byte lane 0 only
			case (aw_a)
				`RLTC_OFS_CTRL: ctrl <= w_s[0] ? w_d[6:0] : ctrl;
				`RLTC_OFS_RETRY: retry <= w_s[0] ? w_d[7:0] : retry;
				`RLTC_OFS_PIPE_EN: pipe_en <= w_s[0] ? w_d[5:0] :
					pipe_en;
				`RLTC_OFS_P0_LO: p0[31:0] <= wmerge(p0[31:0], w_d, w_s);
				`RLTC_OFS_P0_HI: p0[39:32] <= w_s[0] ? w_d[7:0] :
					p0[39:32];
				`RLTC_OFS_P1_LO: p1[31:0] <= wmerge(p1[31:0], w_d, w_s);
				`RLTC_OFS_P1_HI: p1[39:32] <= w_s[0] ? w_d[7:0] :
					p1[39:32];
				`RLTC_OFS_LSB25: lsb25 <= wmerge(lsb25, w_d, w_s);
				default: ;
			endcase
		end
	end

	// read decode
	wire [31:0] rd_val =
		s_axi_araddr == `RLTC_OFS_CTRL ? {25'h0, ctrl} :
		s_axi_araddr == `RLTC_OFS_RETRY ? {24'h0, retry} :
		s_axi_araddr == `RLTC_OFS_STATUS ? {14'h0, radio_mode, 1'b0, state,
			retry_count, 5'h0, f_lim, f_rxr, f_done} :
		s_axi_araddr == `RLTC_OFS_PIPE_EN ? {26'h0, pipe_en} :
		s_axi_araddr == `RLTC_OFS_P0_LO ? p0[31:0] :
		s_axi_araddr == `RLTC_OFS_P0_HI ? {24'h0, p0[39:32]} :
		s_axi_araddr == `RLTC_OFS_P1_LO ? p1[31:0] :
		s_axi_araddr == `RLTC_OFS_P1_HI ? {24'h0, p1[39:32]} :
		s_axi_araddr == `RLTC_OFS_LSB25 ? lsb25 : 32'h0;
	wire rd_ok = s_axi_araddr <= `RLTC_OFS_LSB25 && s_axi_araddr[1:0] == 2'h0;

	// axi read: one registered answer a cycle after the address
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	a_start_new: assert property (go_new |=> tx_start && state == RLTC_TX
		&& retry_count == 4'h0) else $error("new packet not sent");
	a_await_ack: assert property (tx_fin && need_ack |=>
		radio_mode == RLTC_MODE_RX) else $error("no ack wait");
	a_empty_ack: assert property (ack_ok && !rx_has_payload && !f_rxr |=>
		f_done && !f_rxr) else $error("empty ack flags wrong");
	a_payload_ack: assert property (ack_ok && rx_has_payload |=> f_done &&
		f_rxr && state == RLTC_SBY1) else $error("payload ack wrong");
	a_retry_hold: assert property (state == RLTC_SBY1 && retry_pend &&
		dly_tmr > 32'h1 && !role_rx |=> state == RLTC_SBY1)
		else $error("left standby early");
	a_limit_stop: assert property (ack_lost && at_limit |=> f_lim &&
		!retry_pend ##1 state != RLTC_TX) else $error("limit ignored");
	a_capt_lock: assert property (state == RLTC_RX_CAPT && !rx_done |=>
		$stable(rx_pipe)) else $error("pipe changed mid packet");
	a_new_write: assert property (new_pkt |=> rxq_write && f_rxr)
		else $error("new packet lost");
	a_dup_drop: assert property (dup_pkt |=> !rxq_write)
		else $error("repeat written");
	a_ack_dest: assert property (state == RLTC_RX_CAPT && send_ack |=>
		tx_start && tx_dest_addr == paddr[rx_pipe])
		else $error("ack address wrong");
	a_pipe_enable: assert property (state == RLTC_RX_CAPT |->
		pipe_en[rx_pipe] || $past(pipe_en) != pipe_en || !$past(pipe_en[rx_pipe]))
		else $error("disabled pipe captured");
endmodule

// >>> dv/rltc_peer.sv
// peer radio model: drives the air-side inputs of the link controller
module rltc_peer (
	// clock
	input wire logic clk,
	// device transmitter
	input wire logic tx_start,
	output logic tx_end,
	// scenario control: 0 silent, 1 empty ack, 2 payload ack, 3 late ack
	input wire logic [1:0] ack_kind,
	input wire logic [39:0] ack_addr,
	// device receiver
	output logic [39:0] rx_addr,
	output logic rx_addr_valid,
	output logic rx_done,
	output logic rx_crc_ok,
	output logic [1:0] rx_pid,
	output logic [15:0] rx_crc,
	output logic rx_no_ack,
	output logic rx_has_payload
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] pid_cnt = 2'h0;

	// one frame; released lines show the inverse so stale values never match
	task automatic send(input logic [39:0] a, input logic [1:0] p,
		input logic [15:0] c, input logic na, input logic pl);
		rx_addr <= a;
		rx_addr_valid <= 1'b1;
		@(posedge clk);
		rx_addr_valid <= 1'b0;
		rx_addr <= ~a;
		repeat (3) @(posedge clk);
		{rx_pid, rx_crc, rx_no_ack, rx_has_payload} <= {p, c, na, pl};
		rx_crc_ok <= 1'b1;
		rx_done <= 1'b1;
		@(posedge clk);
		{rx_pid, rx_crc, rx_no_ack, rx_has_payload} <= ~{p, c, na, pl};
		rx_crc_ok <= 1'b0;
		rx_done <= 1'b0;
	endtask

	// air side: finish each transmission, then answer as commanded
	initial begin
		{tx_end, rx_addr_valid, rx_done, rx_crc_ok} = '0;
		{rx_addr, rx_pid, rx_crc, rx_no_ack, rx_has_payload} = '0;
		forever begin
			@(posedge clk);
			if (tx_start === 1'b1) begin
				repeat (5) @(posedge clk);
				tx_end <= 1'b1;
				@(posedge clk);
				tx_end <= 1'b0;
				if (ack_kind != 2'h0) begin
					// late answers land well past the ack window
					repeat (ack_kind == 2'h3 ? 12 : 2) @(posedge clk);
					pid_cnt <= pid_cnt + 2'h1;
					send(ack_addr, pid_cnt, 16'hA5C3 ^ {14'h0, pid_cnt}, 1'b0,
						ack_kind == 2'h2);
				end
			end
		end
	end
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the link transaction controller
`include "rltc_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STEP = 20;
	// distinct pipe addresses, reset values of pipes 0, 1 and two others
	localparam logic [39:0] P0 = 40'hE7D3F03577;
	localparam logic [39:0] P1 = 40'hC2C2C2C2C2;
	localparam logic [39:0] P2 = 40'hC2C2C2C2C3;
	localparam logic [39:0] P5 = 40'hC2C2C2C2C6;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rx_pid, radio_mode, ack_kind;
	logic txq_nonempty, txq_skip_ack, txq_pop, tx_start, tx_resend;
	logic tx_ack_payload, tx_end, rx_addr_valid, rx_done, rx_crc_ok;
	logic rx_no_ack, rx_has_payload, rxq_write, crc_on, crc_two;
	logic [39:0] tx_dest_addr, rx_addr, ack_addr;
	logic [15:0] rx_crc;
	logic [2:0] rx_pipe;
	int error_cnt = 0;
	int compares = 0;
	logic [5:0] rst_a [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14,
		6'h18, 6'h1C, 6'h20, 6'h24};
	logic [31:0] rst_v [10] = '{32'h5C, 32'h3, 32'h0, 32'h3, 32'hD3F03577,
		32'hE7, 32'hC2C2C2C2, 32'hC2, 32'hC6C5C4C3, 32'h0};

	rltc_ctrl #(.STEP_CYC(STEP), .ACK_WAIT_CYC(10)) uut (.clk, .srst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .txq_nonempty, .txq_skip_ack, .txq_pop, .tx_start,
		.tx_resend, .tx_ack_payload, .tx_dest_addr, .tx_end, .rx_addr,
		.rx_addr_valid, .rx_done, .rx_crc_ok, .rx_pid, .rx_crc, .rx_no_ack,
		.rx_has_payload, .rxq_write, .rx_pipe, .radio_mode, .crc_on,
		.crc_two);
	rltc_peer peer (.clk, .tx_start, .tx_end, .ack_kind, .ack_addr, .rx_addr,
		.rx_addr_valid, .rx_done, .rx_crc_ok, .rx_pid, .rx_crc, .rx_no_ack,
		.rx_has_payload);

	initial begin
		forever #5 clk = ~clk;
	end

	// cycles from end of a lost packet to its resend
	function automatic int delay_cyc(input logic [3:0] d);
		return (int'(d) + 1) * STEP;
	endfunction

	// status flags {limit, ready, done} after a successful transaction
	function automatic logic [2:0] flags_exp(input int k);
		return {1'b0, k == 2, 1'b1};
	endfunction

	task automatic finish_test();
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic hang();
		error_cnt++;
		$display("BAD %0t timeout", $time);
		finish_test();
	endtask

	// bready rises only once data is taken, so back-to-back calls never clash
	task automatic wr(input logic [5:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
			if (s_axi_wready && s_axi_wvalid) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid === 1'b1 && s_axi_bready) && n < 60);
		if (n >= 60) hang();
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
	endtask

	task automatic rd(input logic [5:0] a, output logic [31:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready && s_axi_arvalid) s_axi_rready <= 1'b1;
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid === 1'b1 && s_axi_rready) && n < 60);
		if (n >= 60) hang();
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		`CHK(s_axi_rresp, er)
	endtask

	task automatic waitp(ref logic s);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (s !== 1'b1 && n < 300);
		if (s !== 1'b1) hang();
	endtask

	// one packet from the peer, then watch store and acknowledgement
	task automatic rxpkt(input logic [39:0] a, input logic [1:0] p,
		input logic [15:0] c, input logic ew, input logic [2:0] ep,
		input logic ea);
		logic w, s;
		w = 1'b0;
		s = 1'b0;
		peer.send(a, p, c, 1'b0, 1'b0);
		repeat (4) begin
			@(posedge clk);
			w |= rxq_write === 1'b1;
			if (rxq_write === 1'b1) `CHK(rx_pipe, ep)
			if (tx_start === 1'b1) begin
				s = 1'b1;
				`CHK(tx_dest_addr, a)
				`CHK(tx_ack_payload, txq_nonempty)
			end
		end
		`CHK(w, ew)
		`CHK(s, ea)
		if (ea) waitp(tx_end);
		repeat (3) @(posedge clk);
	endtask

	initial begin
		logic [31:0] d;
		logic [3:0] dly;
		logic [1:0] pid;
		logic [15:0] crc;
		int n, lo;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_bready, s_axi_rready, txq_nonempty, txq_skip_ack} = '0;
		ack_kind = 2'h0;
		ack_addr = P0;
		void'($urandom(32'hF279));
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		// reset values, last entry unmapped
		for (int i = 0; i < 10; i++) begin
			rd(rst_a[i], d, i == 9 ? 2'h2 : 2'h0);
			`CHK(d, rst_v[i])
		end
		wr(6'h24, 32'hFFFFFFFF, 2'h2);
		for (int i = 0; i < 4; i++) begin
			wr(`RLTC_OFS_CTRL, {25'h0, i[1], i[0] ^ i[1], i[0], 4'h0}, 2'h0);
			@(posedge clk);
			`CHK(crc_on, i[1] | i[0])
			`CHK(crc_two, i[0] ^ i[1])
		end
		// transmitter: a single peer, so any retry delay will do
		dly = 4'($urandom_range(0, 3));
		lo = delay_cyc(dly);
		wr(`RLTC_OFS_RETRY, {24'h0, dly, 4'h2}, 2'h0);
		wr(`RLTC_OFS_CTRL, 32'h5, 2'h0);
		repeat (3) @(posedge clk);
		`CHK(radio_mode, 2'h1)
		ack_kind <= 2'h3;
		txq_nonempty <= 1'b1;
		waitp(tx_start);
		@(posedge clk);
		`CHK(radio_mode, 2'h2)
		// late, misaddressed, then silent answers: all count as lost
		for (int a = 0; a < 3; a++) begin
			waitp(tx_end);
			if (a == 2) txq_nonempty <= 1'b0;
			n = 0;
			do begin
				@(posedge clk);
				n++;
				// after the limit the queue is empty, so standby-II follows
				if (n > 13 && n < lo - 2) `CHK(radio_mode, a == 2 ? 2'h1 : 2'h0)
			end while (tx_start !== 1'b1 && n < lo + 10);
			if (a < 2) `CHK(n >= lo && n <= lo + 3, 1'b1)
			if (a < 2) `CHK(tx_resend, 1'b1)
			if (a == 2) `CHK(tx_start, 1'b0)
			if (a == 0) {ack_kind, ack_addr} <= {2'h1, P1};
			if (a == 1) ack_kind <= 2'h0;
		end
		rd(`RLTC_OFS_STATUS, d, 2'h0);
		`CHK(d[11:8], 4'h2)
		`CHK(d[2:0], 3'b100)
		wr(`RLTC_OFS_STATUS, 32'h7, 2'h0);
		ack_addr <= P0;
		// skip-ack packet, empty ack, payload ack
		for (int k = 0; k < 3; k++) begin
			txq_skip_ack <= k == 0;
			ack_kind <= 2'(k);
			txq_nonempty <= 1'b1;
			waitp(tx_start);
			`CHK(tx_resend, 1'b0)
			`CHK(tx_dest_addr, P0)
			waitp(tx_end);
			n = 0;
			do begin
				@(posedge clk);
				n++;
				if (n == 1) `CHK(radio_mode == 2'h3, k != 0)
			end while (txq_pop !== 1'b1 && n < 40);
			if (n >= 40) hang();
			txq_nonempty <= 1'b0;
			rd(`RLTC_OFS_STATUS, d, 2'h0);
			`CHK(d[2:0], flags_exp(k))
			`CHK(d[11:8], 4'h0)
			wr(`RLTC_OFS_STATUS, 32'h7, 2'h0);
		end
		// receiver role with auto acknowledgement
		txq_skip_ack <= 1'b0;
		ack_kind <= 2'h0;
		wr(`RLTC_OFS_CTRL, 32'hB, 2'h0);
		repeat (3) @(posedge clk);
		`CHK(radio_mode, 2'h3)
		pid = 2'($urandom);
		crc = 16'($urandom);
		txq_nonempty <= 1'b1;
		rxpkt(P1, pid, crc, 1'b1, 3'h1, 1'b1);
		rd(`RLTC_OFS_STATUS, d, 2'h0);
		`CHK(d[1:0], 2'b10)
		// the repeat is answered with a payload too, so the next new packet
		// reports that payload as delivered
		rxpkt(P1, pid, crc, 1'b0, 3'h1, 1'b1);
		txq_nonempty <= 1'b0;
		rxpkt(P2, pid + 2'h1, crc, 1'b0, 3'h2, 1'b0);
		wr(`RLTC_OFS_PIPE_EN, 32'h3F, 2'h0);
		rxpkt(P5, pid, crc ^ 16'h1, 1'b1, 3'h5, 1'b1);
		rd(`RLTC_OFS_STATUS, d, 2'h0);
		`CHK(d[0], 1'b1)
		finish_test();
	end
endmodule
